// file: rtl/plsc_core_end.sv
// Purpose: core end of the local back-end link: strobes, mirrors, interrupt, target
// Assumes: bus engine signals arrive on clk_sys; back-end shares clk_sys
// Notes:   master write words pass an 8-entry buffer before the bus engine
`timescale 1ns/100ps
module plsc_core_end
	import plsc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	plsc_local_if.core                  lif,
	input  wire logic                   bus_master_run,
	input  wire logic                   bus_master_read,
	input  wire logic                   bus_wide_active,
	input  wire logic                   bus_rd_valid,
	input  wire logic [2*DWORD_W-1:0]   bus_rd_data,
	output logic                        bus_rd_taken,
	output logic                        bus_wr_valid,
	input  wire logic                   bus_wr_ready,
	output logic [2*DWORD_W-1:0]        bus_wr_data,
	output logic [HI_BE_W-1:0]          bus_wr_hi_be_n,
	input  wire logic                   bus_tgt_access,
	input  wire logic                   bus_tgt_read,
	output logic                        bus_tgt_abort,
	output logic                        bus_tgt_stop,
	output logic                        bus_tgt_ready,
	input  wire logic                   cfg_int_enable,
	input  wire logic [CACHE_W-1:0]     cfg_cache,
	input  wire logic [CMD_SRC_W-1:0]   cfg_command,
	input  wire logic [STS_SRC_W-1:0]   cfg_status,
	output logic                        inta_n
);
	localparam int FW = 2*DWORD_W+HI_BE_W;
	localparam int LW = $clog2(DEPTH)+1;

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (DEPTH < 2)
	begin : g_bad
		$error("plsc_core_end: buffer depth below 2");
	end

	typedef enum logic [1:0] {PLSC_IDLE, PLSC_WRITE, PLSC_READ} plsc_mst_t;

	plsc_mst_t        mst_q;
	plsc_mst_t        mst_d;
	logic             strobe_q;
	logic             strobe_d;
	logic             wide_q;
	logic             rd_taken_q;
	logic [2*DWORD_W-1:0] out_word_q;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	logic [FW-1:0]    fifo_out_data;
	logic [LW-1:0]    fifo_level;
	logic [STS_W-1:0] sts_d;
	logic             push;

	// ------------------------------------------------------------
	// master sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		mst_d = mst_q;
		case (mst_q)
			PLSC_IDLE:
				if (bus_master_run)
					mst_d = bus_master_read ? PLSC_READ : PLSC_WRITE;
			PLSC_WRITE:
				if (!bus_master_run)
					mst_d = PLSC_IDLE;
			PLSC_READ:
				if (!bus_master_run)
					mst_d = PLSC_IDLE;
			default:
				mst_d = PLSC_IDLE;
		endcase
	end

	// strobe look-ahead: a write strobe only when a buffer slot is certain,
	// counting the word already in flight, so no consumed word is dropped
	always_comb
	begin
		strobe_d = 1'b0;
		case (mst_q)
			PLSC_WRITE:
				strobe_d = bus_master_run && fifo_in_ready &&
					(fifo_level + LW'(strobe_q) < LW'(DEPTH));
			PLSC_READ:
				strobe_d = bus_master_run && bus_rd_valid && !rd_taken_q;
			default:
				strobe_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			mst_q <= PLSC_IDLE;
		else if (ce)
			mst_q <= mst_d;
	end

	// ------------------------------------------------------------
	// transfer strobes and wide indication
	// ------------------------------------------------------------
	// the 32-bit strobe serves narrow transfers only; wide ones use both halves
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			strobe_q                      <= 1'b0;
			wide_q                        <= 1'b0;
			lif.master_xfer_strobe_n      <= 1'b1;
			lif.master_low_word_strobe_n  <= 1'b1;
			lif.master_high_word_strobe_n <= 1'b1;
			lif.master_wide_xfer_active_n <= 1'b1;
			lif.master_read_not_write     <= 1'b0;
		end
		else if (ce)
		begin
			strobe_q                      <= strobe_d;
			wide_q                        <= bus_wide_active;
			lif.master_xfer_strobe_n      <= !(strobe_d && !bus_wide_active);
			lif.master_low_word_strobe_n  <= !(strobe_d && bus_wide_active);
			lif.master_high_word_strobe_n <= !(strobe_d && bus_wide_active);
			lif.master_wide_xfer_active_n <= !bus_wide_active;
			lif.master_read_not_write     <= (mst_d == PLSC_READ);
		end
	end

	// ------------------------------------------------------------
	// read data toward the back-end
	// ------------------------------------------------------------
	// the word is loaded with its strobe, so it is valid in the strobe cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			out_word_q   <= {WORD_RST, WORD_RST};
			rd_taken_q   <= 1'b0;
			bus_rd_taken <= 1'b0;
		end
		else if (ce)
		begin
			rd_taken_q   <= strobe_d && (mst_q == PLSC_READ);
			bus_rd_taken <= strobe_d && (mst_q == PLSC_READ);
			if (strobe_d && mst_q == PLSC_READ)
				out_word_q <= bus_rd_data;
		end
	end

	assign lif.local_out_word = out_word_q;

	// ------------------------------------------------------------
	// write data buffer
	// ------------------------------------------------------------
	// the input word is taken in the strobe cycle itself
	assign push = strobe_q && (mst_q == PLSC_WRITE);

	plsc_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH)
	) u_wr_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({lif.master_byte_lane_en_n, lif.local_in_word}),
		.out_valid (fifo_out_valid),
		.out_ready (bus_wr_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// narrow transfers carry no upper lanes, so their upper enables read as off
	assign bus_wr_valid   = fifo_out_valid;
	assign bus_wr_data    = fifo_out_data[2*DWORD_W-1:0];
	assign bus_wr_hi_be_n = fifo_out_data[FW-1:2*DWORD_W] | {HI_BE_W{!wide_q}};

	// ------------------------------------------------------------
	// local target requests and direction
	// ------------------------------------------------------------
	// requests count only inside an access so a stale level cannot end the next one
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			bus_tgt_abort          <= 1'b0;
			bus_tgt_stop           <= 1'b0;
			bus_tgt_ready          <= 1'b0;
			lif.tgt_read_not_write <= 1'b0;
		end
		else if (ce)
		begin
			bus_tgt_abort <= bus_tgt_access && !lif.tgt_abort_req_n;
			bus_tgt_stop  <= bus_tgt_access && !lif.tgt_early_stop_req_n &&
				lif.tgt_abort_req_n;
			bus_tgt_ready <= bus_tgt_access && !lif.tgt_ready_n;
			if (bus_tgt_access)
				lif.tgt_read_not_write <= bus_tgt_read;
		end
	end

	// ------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			inta_n <= 1'b1;
		else if (ce)
			inta_n <= !(!lif.local_irq_n && cfg_int_enable);
	end

	// ------------------------------------------------------------
	// configuration mirrors
	// ------------------------------------------------------------
	for (genvar i = 0; i < STS_W; i++)
	begin : g_sts
		assign sts_d[i] = cfg_status[STS_SRC_POS[i]];
	end

	// one register stage: the back-end sees a change one cycle later
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			lif.cfg_cache_line   <= CACHE_RST;
			lif.cfg_command_bits <= CMD_RST;
			lif.cfg_status_bits  <= STS_RST;
		end
		else if (ce)
		begin
			lif.cfg_cache_line   <= cfg_cache;
			lif.cfg_command_bits <= cfg_command[CMD_W-1:0] &
				~(CMD_W'(1) << CMD_RSVD_BIT);
			lif.cfg_status_bits  <= sts_d;
		end
	end
endmodule

// file: inc/plsc_pkg.sv
// Purpose: shared constants for the local-side control of the bus interface core
// Assumes: one clock, both ends and the data buffer use the same clk_sys
// Notes:   mirror field positions and buffer sizes live here and nowhere else
//
// Overview of operation
// - wide mode: low word strobe marks each transfer
// - wide mode: high word strobe marks each transfer
// - wide indication low while wide transaction runs
// - back-end drives upper byte lane enables
// - local interrupt plus enable raises bus interrupt
// - cache line size mirrored on output bus
// - command bits zero to three mirrored
// - command bits four to nine mirrored, seven reserved
// - status bits eight, eleven, twelve mirrored
// - status bits thirteen to fifteen mirrored
// - local abort request gives target abort
// - local early stop request ends transaction early
// - back-end ready only when it can move data
// - direction output high read, low write
// - word consumed or valid in strobe cycle
package plsc_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int DWORD_W    = 32;
	localparam int HI_BE_W    = 4;
	localparam int CACHE_W    = 8;
	localparam int CMD_SRC_W  = 16;
	localparam int CMD_W      = 10;
	localparam int STS_SRC_W  = 16;
	localparam int STS_W      = 6;
	localparam int FIFO_DEPTH = 8;

	// ------------------------------------------------------------
	// mirror field positions
	// ------------------------------------------------------------
	localparam int CMD_RSVD_BIT   = 7;
	localparam int STS_MDPE_SRC   = 8;
	localparam int STS_STA_SRC    = 11;
	localparam int STS_RTA_SRC    = 12;
	localparam int STS_RMA_SRC    = 13;
	localparam int STS_SSE_SRC    = 14;
	localparam int STS_DPE_SRC    = 15;
	localparam int STS_SRC_POS [STS_W] = '{STS_MDPE_SRC, STS_STA_SRC, STS_RTA_SRC,
		STS_RMA_SRC, STS_SSE_SRC, STS_DPE_SRC};

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [CACHE_W-1:0] CACHE_RST = 8'h00;
	localparam logic [CMD_W-1:0]   CMD_RST   = 10'h000;
	localparam logic [STS_W-1:0]   STS_RST   = 6'h00;
	localparam logic [DWORD_W-1:0] WORD_RST  = 32'h00000000;
	localparam logic [HI_BE_W-1:0] BE_RST_N  = 4'hF;
endpackage

// file: inc/plsc_local_if.sv
// Purpose: local back-end link between the core end and the user back-end end
// Assumes: all signals are on clk_sys; active-low names end in _n
// Notes:   no clocking block; the bench joins the two ends through this
`timescale 1ns/100ps
interface plsc_local_if
	import plsc_pkg::*;
();
	logic                 master_xfer_strobe_n;
	logic                 master_low_word_strobe_n;
	logic                 master_high_word_strobe_n;
	logic                 master_wide_xfer_active_n;
	logic                 master_read_not_write;
	logic [HI_BE_W-1:0]   master_byte_lane_en_n;
	logic [2*DWORD_W-1:0] local_in_word;
	logic [2*DWORD_W-1:0] local_out_word;
	logic                 local_irq_n;
	logic [CACHE_W-1:0]   cfg_cache_line;
	logic [CMD_W-1:0]     cfg_command_bits;
	logic [STS_W-1:0]     cfg_status_bits;
	logic                 tgt_abort_req_n;
	logic                 tgt_early_stop_req_n;
	logic                 tgt_ready_n;
	logic                 tgt_read_not_write;

	modport core
	(
		output master_xfer_strobe_n, master_low_word_strobe_n, master_high_word_strobe_n,
		output master_wide_xfer_active_n, master_read_not_write, local_out_word,
		output cfg_cache_line, cfg_command_bits, cfg_status_bits, tgt_read_not_write,
		input  master_byte_lane_en_n, local_in_word, local_irq_n,
		input  tgt_abort_req_n, tgt_early_stop_req_n, tgt_ready_n
	);

	modport backend
	(
		input  master_xfer_strobe_n, master_low_word_strobe_n, master_high_word_strobe_n,
		input  master_wide_xfer_active_n, master_read_not_write, local_out_word,
		input  cfg_cache_line, cfg_command_bits, cfg_status_bits, tgt_read_not_write,
		output master_byte_lane_en_n, local_in_word, local_irq_n,
		output tgt_abort_req_n, tgt_early_stop_req_n, tgt_ready_n
	);
endinterface

// file: rtl/plsc_fifo.sv
// Purpose: flip-flop FIFO between back-end write words and the bus engine
// Assumes: single clock, depth a power of two
// Notes:   valid and ready come from flops; level shows fill for look-ahead
`timescale 1ns/100ps
module plsc_fifo
	import plsc_pkg::*;
#(
	parameter int WIDTH = 2*DWORD_W+HI_BE_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [WIDTH-1:0]       in_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic [WIDTH-1:0]            out_data,
	output logic [$clog2(DEPTH):0]      level
);
	localparam int AW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad
		$error("plsc_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign level    = count_q;
	assign out_data = mem_q[rd_ptr_q];

	// ------------------------------------------------------------
	// fill count and flags
	// ------------------------------------------------------------
	always_comb
	begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + (AW+1)'(1);
		else if (pop && !push)
			count_d = count_q - (AW+1)'(1);
	end

	// flags are registered so the far side sees clean levels
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			count_q   <= '0;
			out_valid <= 1'b0;
			in_ready  <= 1'b1;
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
		end
		else if (ce)
		begin
			count_q   <= count_d;
			out_valid <= (count_d != '0);
			in_ready  <= (count_d != (AW+1)'(DEPTH));
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
		end
	end

	// storage has no reset; only written entries are ever read
	always_ff @(posedge clk_sys)
	begin
		if (ce && push)
			mem_q[wr_ptr_q] <= in_data;
	end
endmodule

// file: rtl/plsc_backend_end.sv
// Purpose: user back-end end of the local link: supplies words, takes words, target replies
// Assumes: user inputs are on clk_sys
// Notes:   next write word is loaded on each strobe; user sees a one-cycle take pulse
`timescale 1ns/100ps
module plsc_backend_end
	import plsc_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	plsc_local_if.backend               lif,
	input  wire logic [2*DWORD_W-1:0]   usr_wr_word,
	input  wire logic [HI_BE_W-1:0]     usr_hi_be_n,
	output logic                        usr_wr_taken,
	output logic                        usr_rd_valid,
	output logic [2*DWORD_W-1:0]        usr_rd_word,
	input  wire logic                   usr_irq,
	input  wire logic                   usr_tgt_abort,
	input  wire logic                   usr_tgt_stop,
	input  wire logic                   usr_tgt_ready,
	output logic                        usr_wide_active,
	output logic                        usr_tgt_read
);
	logic strobe;

	// any strobe marks one consumed or delivered word
	assign strobe = !lif.master_xfer_strobe_n || !lif.master_low_word_strobe_n;

	// ------------------------------------------------------------
	// master words
	// ------------------------------------------------------------
	// the next word follows in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			lif.local_in_word         <= {WORD_RST, WORD_RST};
			lif.master_byte_lane_en_n <= BE_RST_N;
			usr_wr_taken              <= 1'b0;
			usr_rd_valid              <= 1'b0;
			usr_rd_word               <= {WORD_RST, WORD_RST};
			usr_wide_active           <= 1'b0;
		end
		else if (ce)
		begin
			usr_wr_taken    <= strobe && !lif.master_read_not_write;
			usr_rd_valid    <= strobe && lif.master_read_not_write;
			usr_wide_active <= !lif.master_wide_xfer_active_n;
			if (strobe && lif.master_read_not_write)
				usr_rd_word <= lif.local_out_word;
			if (strobe || lif.master_xfer_strobe_n && lif.master_low_word_strobe_n)
			begin
				lif.local_in_word         <= usr_wr_word;
				lif.master_byte_lane_en_n <= usr_hi_be_n;
			end
		end
	end

	// ------------------------------------------------------------
	// target replies and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			lif.tgt_abort_req_n      <= 1'b1;
			lif.tgt_early_stop_req_n <= 1'b1;
			lif.tgt_ready_n          <= 1'b1;
			lif.local_irq_n          <= 1'b1;
			usr_tgt_read             <= 1'b0;
		end
		else if (ce)
		begin
			lif.tgt_abort_req_n      <= !usr_tgt_abort;
			lif.tgt_early_stop_req_n <= !usr_tgt_stop;
			lif.tgt_ready_n          <= !usr_tgt_ready;
			lif.local_irq_n          <= !usr_irq;
			usr_tgt_read             <= lif.tgt_read_not_write;
		end
	end
endmodule

// file: verification/plsc_link_assertions.sv
// Purpose: concurrent checks on the local link between the core end and the back-end end
// Assumes: one clock clk_sys, nrst asynchronous active low
// Notes:   sees only the link signals, so bus-side causes are judged by the bench
`timescale 1ns/100ps
module plsc_link_assertions
	import plsc_pkg::*;
(
	input wire logic               clk_sys,
	input wire logic               nrst,
	input wire logic               master_xfer_strobe_n,
	input wire logic               master_low_word_strobe_n,
	input wire logic               master_high_word_strobe_n,
	input wire logic               master_wide_xfer_active_n,
	input wire logic               master_read_not_write,
	input wire logic [CMD_W-1:0]   cfg_command_bits
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// helper
	// ------------------------------------------------------------
	// any strobe low, narrow or wide
	logic strobe_any;
	assign strobe_any = !master_xfer_strobe_n || !master_low_word_strobe_n;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	wide_pair_a: assert property (master_low_word_strobe_n == master_high_word_strobe_n)
		else $error("wide word strobes out of step");
	narrow_excl_a: assert property (!master_xfer_strobe_n |-> master_low_word_strobe_n)
		else $error("narrow and wide strobes together");
	wide_flag_a: assert property (!master_low_word_strobe_n |-> !master_wide_xfer_active_n)
		else $error("wide strobe without wide flag");
	narrow_flag_a: assert property (!master_xfer_strobe_n |-> master_wide_xfer_active_n)
		else $error("narrow strobe during wide transfer");
	narrow_gap_a: assert property (master_read_not_write && !master_xfer_strobe_n ##1
		master_read_not_write |-> master_xfer_strobe_n)
		else $error("narrow read strobes back to back");
	wide_gap_a: assert property (master_read_not_write && !master_low_word_strobe_n ##1
		master_read_not_write |-> master_low_word_strobe_n)
		else $error("wide read strobes back to back");
	dir_idle_a: assert property ($changed(master_read_not_write) |-> !strobe_any)
		else $error("direction changed during a strobe");
	cmd_rsvd_a: assert property (cfg_command_bits[CMD_RSVD_BIT] == 1'b0)
		else $error("reserved command bit set");
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench joining the core end and the back-end end
// Assumes: 40 MHz clk_sys, inputs driven by non-blocking assignment on the rising edge
// Notes:   random values from a 16-bit shift register; corner values mixed in
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench
	import plsc_pkg::*;
;
	logic clk_sys, nrst, ce, bus_master_run, bus_master_read, bus_wide_active, bus_rd_valid;
	logic bus_rd_taken, bus_wr_valid, bus_wr_ready, bus_tgt_access, bus_tgt_read;
	logic bus_tgt_abort, bus_tgt_stop, bus_tgt_ready, cfg_int_enable, inta_n;
	logic usr_wr_taken, usr_rd_valid, usr_irq, usr_tgt_abort, usr_tgt_stop, usr_tgt_ready;
	logic usr_wide_active, usr_tgt_read;
	logic [2*DWORD_W-1:0] bus_rd_data, bus_wr_data, usr_wr_word, usr_rd_word, word, mask;
	logic [HI_BE_W-1:0]   bus_wr_hi_be_n, usr_hi_be_n;
	logic [CACHE_W-1:0]   cfg_cache;
	logic [15:0]          cfg_command, cfg_status, lfsr_q;
	int                   bad_count, n_checks, cnt, beats, taken;

	plsc_local_if plsc_local_if_i ();

	plsc_core_end #(.DEPTH(FIFO_DEPTH)) plsc_core_end_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.lif(plsc_local_if_i), .bus_master_run(bus_master_run), .bus_master_read(bus_master_read),
		.bus_wide_active(bus_wide_active), .bus_rd_valid(bus_rd_valid), .bus_rd_data(bus_rd_data),
		.bus_rd_taken(bus_rd_taken), .bus_wr_valid(bus_wr_valid), .bus_wr_ready(bus_wr_ready),
		.bus_wr_data(bus_wr_data), .bus_wr_hi_be_n(bus_wr_hi_be_n),
		.bus_tgt_access(bus_tgt_access), .bus_tgt_read(bus_tgt_read),
		.bus_tgt_abort(bus_tgt_abort), .bus_tgt_stop(bus_tgt_stop), .bus_tgt_ready(bus_tgt_ready),
		.cfg_int_enable(cfg_int_enable), .cfg_cache(cfg_cache), .cfg_command(cfg_command),
		.cfg_status(cfg_status), .inta_n(inta_n));

	plsc_backend_end plsc_backend_end_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.lif(plsc_local_if_i), .usr_wr_word(usr_wr_word), .usr_hi_be_n(usr_hi_be_n),
		.usr_wr_taken(usr_wr_taken), .usr_rd_valid(usr_rd_valid), .usr_rd_word(usr_rd_word),
		.usr_irq(usr_irq), .usr_tgt_abort(usr_tgt_abort), .usr_tgt_stop(usr_tgt_stop),
		.usr_tgt_ready(usr_tgt_ready), .usr_wide_active(usr_wide_active),
		.usr_tgt_read(usr_tgt_read));

	plsc_link_assertions plsc_link_assertions_i (.clk_sys(clk_sys), .nrst(nrst),
		.master_xfer_strobe_n(plsc_local_if_i.master_xfer_strobe_n),
		.master_low_word_strobe_n(plsc_local_if_i.master_low_word_strobe_n),
		.master_high_word_strobe_n(plsc_local_if_i.master_high_word_strobe_n),
		.master_wide_xfer_active_n(plsc_local_if_i.master_wide_xfer_active_n),
		.master_read_not_write(plsc_local_if_i.master_read_not_write),
		.cfg_command_bits(plsc_local_if_i.cfg_command_bits));

	// ------------------------------------------------------------
	// expectations and random source
	// ------------------------------------------------------------
	// reserved bit seven reads zero whatever the source holds
	function automatic logic [CMD_W-1:0] exp_cmd(input logic [15:0] c);
		return {c[9:8], 1'b0, c[6:0]};
	endfunction
	function automatic logic [STS_W-1:0] exp_sts(input logic [15:0] s);
		return {s[15:11], s[8]};
	endfunction
	function automatic logic [15:0] rnd16();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction

	// ------------------------------------------------------------
	// clock and closing report
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		{bus_master_run, bus_master_read, bus_wide_active, bus_rd_valid, bus_wr_ready} = '0;
		{bus_tgt_access, bus_tgt_read, cfg_int_enable, usr_irq} = '0;
		{usr_tgt_abort, usr_tgt_stop, usr_tgt_ready} = '0;
		{bus_rd_data, usr_wr_word, cfg_cache, cfg_command, cfg_status} = '0;
		usr_hi_be_n = 4'hF;
		lfsr_q = 16'h56C5;
		bad_count = 0;
		n_checks = 0;
		ce = 1'b1;
		nrst = 1'b0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		// mirrors follow one cycle after the source; all ones first as a corner
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_sys);
			cfg_cache <= (i == 0) ? 8'hFF : CACHE_W'(rnd16());
			cfg_command <= (i == 0) ? 16'hFFFF : rnd16();
			cfg_status <= (i == 0) ? 16'hFFFF : rnd16();
			@(posedge clk_sys);
			@(negedge clk_sys);
			`CHK(plsc_local_if_i.cfg_cache_line, cfg_cache)
			`CHK(plsc_local_if_i.cfg_command_bits, exp_cmd(cfg_command))
			`CHK(plsc_local_if_i.cfg_status_bits, exp_sts(cfg_status))
		end
		// a low clock enable freezes the mirrors whatever the source does
		@(posedge clk_sys);
		ce <= 1'b0;
		cfg_cache <= ~cfg_cache;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(plsc_local_if_i.cfg_cache_line, ~cfg_cache)
		@(posedge clk_sys);
		ce <= 1'b1;
		// every request and enable pairing
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			usr_irq <= i[0];
			cfg_int_enable <= i[1];
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			`CHK(inta_n, ~(i[0] & i[1]))
		end
		// target replies for all request mixes, abort taking precedence over early stop
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk_sys);
			bus_tgt_access <= (i < 8);
			// direction only moves inside an access, so keep it outside one
			bus_tgt_read <= (i < 8) ? 1'(rnd16()) : bus_tgt_read;
			{usr_tgt_ready, usr_tgt_stop, usr_tgt_abort} <= i[2:0];
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			`CHK(bus_tgt_abort, (i < 8) & i[0])
			`CHK(bus_tgt_stop, (i < 8) & i[1] & ~i[0])
			`CHK(bus_tgt_ready, (i < 8) & i[2])
			`CHK(plsc_local_if_i.tgt_read_not_write, bus_tgt_read)
			`CHK(usr_tgt_read, bus_tgt_read)
		end
		// write burst against a stalled bus, then a read burst, narrow then wide
		for (int w = 0; w < 2; w++)
		begin
			word = {rnd16(), rnd16(), rnd16(), rnd16()};
			mask = w ? '1 : 64'h00000000FFFFFFFF;
			cnt = 0;
			beats = 0;
			taken = 0;
			@(posedge clk_sys);
			bus_wide_active <= w[0];
			usr_wr_word <= word;
			usr_hi_be_n <= HI_BE_W'(rnd16());
			for (int k = 0; k < 70; k++)
			begin
				@(posedge clk_sys);
				if (k == 3)
					bus_master_run <= 1'b1;
				if (k == 33)
				begin
					bus_master_run <= 1'b0;
					bus_wr_ready <= 1'b1;
				end
				@(negedge clk_sys);
				if (k == 10)
				begin
					`CHK(plsc_local_if_i.master_wide_xfer_active_n, ~w[0])
					`CHK(usr_wide_active, w[0])
				end
				taken += (usr_wr_taken === 1'b1);
				// a wide word counts only when both halves strobe together
				if (k < 33)
					cnt += w ? !(plsc_local_if_i.master_low_word_strobe_n |
						plsc_local_if_i.master_high_word_strobe_n)
						: !plsc_local_if_i.master_xfer_strobe_n;
				else if (bus_wr_valid === 1'b1)
				begin
					beats++;
					`CHK(bus_wr_data & mask, word & mask)
					`CHK(bus_wr_hi_be_n, w ? usr_hi_be_n : 4'hF)
				end
			end
			`CHK(cnt, FIFO_DEPTH)
			`CHK(beats, FIFO_DEPTH)
			`CHK(taken, FIFO_DEPTH)
			word = {rnd16(), rnd16(), rnd16(), rnd16()};
			cnt = 0;
			beats = 0;
			@(posedge clk_sys);
			bus_wr_ready <= 1'b0;
			bus_rd_data <= word;
			for (int k = 0; k < 30; k++)
			begin
				@(posedge clk_sys);
				bus_master_run <= (k < 24);
				bus_master_read <= (k < 24);
				bus_rd_valid <= (k > 2 && k < 24);
				@(negedge clk_sys);
				if (k == 12)
					`CHK(plsc_local_if_i.master_read_not_write, 1'b1)
				cnt += (bus_rd_taken === 1'b1);
				if (usr_rd_valid === 1'b1)
				begin
					beats++;
					`CHK(usr_rd_word & mask, word & mask)
				end
			end
			`CHK(beats, cnt)
			`CHK(cnt > 0, 1'b1)
		end
		results();
	end
endmodule
